/* rtl/fplsc_top.sv */
// Floating-point load/store format conversion with update-form write-back.
// Assumes one operation per valid pulse; memory and register data are synchronous.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: Single load widens 32-bit memory word to double before register write.
// RQ2: Double load copies memory doubleword into register unchanged.
// RQ3: Update load with nonzero base writes address to base and loads data.
// RQ4: Update load with base field zero is flagged as invalid form.
// RQ5: Single store narrows double register value to 32-bit word.
// RQ6: Exponent above 896 or zero magnitude: word takes bits 0-1 and 5-34.
// RQ7: Too-large magnitudes use the same plain bit-extraction path.
// RQ8: Double store and integer-word store write register bits unchanged.
// RQ9: Converted results match the algorithmic model bit for bit.
// RQ10: Denormal cases use IEEE rebiasing and fraction shifting.
module fplsc_top
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire fplsc_pkg::fplsc_op_t op_code,
   input wire logic op_update,
   input wire logic [4:0] base_gpr,
   input wire logic [4:0] fp_target_reg,
   input wire logic [63:0] eff_addr,
   input wire logic [63:0] mem_rdata,
   input wire logic [63:0] fp_source_reg,
   output logic fpr_we,
   output logic [4:0] fpr_waddr,
   output logic [63:0] fpr_wdata,
   output logic gpr_we,
   output logic [4:0] gpr_waddr,
   output logic [63:0] gpr_wdata,
   output logic mem_we,
   output logic mem_dword,
   output logic [63:0] mem_wdata,
   output logic invalid_form
);
   // ------------------------------------------------------------
   // Conversion
   // ------------------------------------------------------------
   logic [63:0] widened;
   logic [31:0] narrowed;
   fplsc_convert u_conv
   (
      .sgl_in(mem_rdata[31:0]),
      .dbl_in(fp_source_reg),
      .dbl_out(widened),
      .sgl_out(narrowed)
   );
   // ------------------------------------------------------------
   // Result registers
   // ------------------------------------------------------------
   logic fpr_we_q, fpr_we_d, gpr_we_q, gpr_we_d, mem_we_q, mem_we_d;
   logic mem_dword_q, mem_dword_d, invalid_q, invalid_d;
   logic [4:0] fpr_waddr_q, fpr_waddr_d, gpr_waddr_q, gpr_waddr_d;
   logic [63:0] fpr_wdata_q, fpr_wdata_d, gpr_wdata_q, gpr_wdata_d;
   logic [63:0] mem_wdata_q, mem_wdata_d;
   logic is_load;
   always_comb
   begin
      is_load = (op_code == fplsc_pkg::FPLSC_OP_LD_SINGLE) ||
                (op_code == fplsc_pkg::FPLSC_OP_LD_DOUBLE);
      fpr_we_d = 1'b0;
      gpr_we_d = 1'b0;
      mem_we_d = 1'b0;
      mem_dword_d = mem_dword_q;
      invalid_d = 1'b0;
      fpr_waddr_d = fpr_waddr_q;
      fpr_wdata_d = fpr_wdata_q;
      gpr_waddr_d = gpr_waddr_q;
      gpr_wdata_d = gpr_wdata_q;
      mem_wdata_d = mem_wdata_q;
      if (op_valid && is_load && op_update && base_gpr == fplsc_pkg::GPR_ZERO)
      begin
         invalid_d = 1'b1; // RQ4
      end
      else if (op_valid)
      begin
         case (op_code)
            fplsc_pkg::FPLSC_OP_LD_SINGLE:
            begin
               fpr_we_d = 1'b1;
               fpr_wdata_d = widened; // RQ1
            end
            fplsc_pkg::FPLSC_OP_LD_DOUBLE:
            begin
               fpr_we_d = 1'b1;
               fpr_wdata_d = mem_rdata; // RQ2
            end
            fplsc_pkg::FPLSC_OP_ST_SINGLE:
            begin
               mem_we_d = 1'b1;
               mem_dword_d = 1'b0;
               mem_wdata_d = {32'h0, narrowed}; // RQ5
            end
            fplsc_pkg::FPLSC_OP_ST_DOUBLE:
            begin
               mem_we_d = 1'b1;
               mem_dword_d = 1'b1;
               mem_wdata_d = fp_source_reg; // RQ8
            end
            fplsc_pkg::FPLSC_OP_ST_INTWORD:
            begin
               mem_we_d = 1'b1;
               mem_dword_d = 1'b0;
               mem_wdata_d = {32'h0, fp_source_reg[31:0]}; // RQ8
            end
            default:
            begin
               invalid_d = 1'b1;
            end
         endcase
         if (is_load)
         begin
            fpr_waddr_d = fp_target_reg;
         end
         if (is_load && op_update)
         begin
            gpr_we_d = 1'b1; // RQ3
            gpr_waddr_d = base_gpr;
            gpr_wdata_d = eff_addr;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fpr_we_q <= 1'b0;
         gpr_we_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_dword_q <= 1'b0;
         invalid_q <= 1'b0;
         fpr_waddr_q <= 5'h00;
         gpr_waddr_q <= 5'h00;
         fpr_wdata_q <= 64'h0000000000000000;
         gpr_wdata_q <= 64'h0000000000000000;
         mem_wdata_q <= 64'h0000000000000000;
      end
      else
      begin
         fpr_we_q <= fpr_we_d;
         gpr_we_q <= gpr_we_d;
         mem_we_q <= mem_we_d;
         mem_dword_q <= mem_dword_d;
         invalid_q <= invalid_d;
         fpr_waddr_q <= fpr_waddr_d;
         gpr_waddr_q <= gpr_waddr_d;
         fpr_wdata_q <= fpr_wdata_d;
         gpr_wdata_q <= gpr_wdata_d;
         mem_wdata_q <= mem_wdata_d;
      end
   end
   assign fpr_we = fpr_we_q;
   assign fpr_waddr = fpr_waddr_q;
   assign fpr_wdata = fpr_wdata_q;
   assign gpr_we = gpr_we_q;
   assign gpr_waddr = gpr_waddr_q;
   assign gpr_wdata = gpr_wdata_q;
   assign mem_we = mem_we_q;
   assign mem_dword = mem_dword_q;
   assign mem_wdata = mem_wdata_q;
   assign invalid_form = invalid_q;
endmodule // fplsc_top
`default_nettype wire

/* rtl/fplsc_pkg.sv */
// Package for the floating-point load/store format conversion datapath.
// Assumes bit 0 of each architectural field is the most significant bit.
package fplsc_pkg;
   // ------------------------------------------------------------
   // Operation codes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FPLSC_OP_LD_SINGLE = 3'h0,
      FPLSC_OP_LD_DOUBLE = 3'h1,
      FPLSC_OP_ST_SINGLE = 3'h2,
      FPLSC_OP_ST_DOUBLE = 3'h3,
      FPLSC_OP_ST_INTWORD = 3'h4
   } fplsc_op_t;
   // ------------------------------------------------------------
   // Formats
   // ------------------------------------------------------------
   localparam int unsigned DBL_EXP_W = 11;
   localparam int unsigned SGL_EXP_W = 8;
   localparam int unsigned SGL_FRAC_W = 23;
   localparam int unsigned DBL_FRAC_W = 52;
   localparam logic [10:0] DBL_EXP_ALL1 = 11'h7FF;
   localparam logic [7:0] SGL_EXP_ALL1 = 8'hFF;
   localparam logic [10:0] SGL_TO_DBL_BIAS = 11'h380;
   localparam logic [10:0] ST_NODENORM_EXP = 11'h380;
   localparam logic [10:0] ST_DENORM_MIN_EXP = 11'h36A;
   localparam logic [4:0] GPR_ZERO = 5'h00;
   localparam int unsigned GPR_IDX_W = 5;
endpackage

/* rtl/fplsc_convert.sv */
// Combinational single/double format conversion.
// Assumes operands are presented in the core clock domain by the caller.
`timescale 1ns/1ps
`default_nettype none
module fplsc_convert
(
   input wire logic [31:0] sgl_in,
   input wire logic [63:0] dbl_in,
   output logic [63:0] dbl_out,
   output logic [31:0] sgl_out
);
   // ------------------------------------------------------------
   // Widening of a single operand
   // ------------------------------------------------------------
   always_comb
   begin
      logic [7:0] e;
      logic [22:0] f;
      logic [51:0] fr;
      logic [10:0] de;
      e = sgl_in[30:23];
      f = sgl_in[22:0];
      fr = {f, 29'h0};
      de = 11'h0;
      if (e == fplsc_pkg::SGL_EXP_ALL1)
      begin
         dbl_out = {sgl_in[31], fplsc_pkg::DBL_EXP_ALL1, fr};
      end
      else if (e != 8'h00)
      begin
         dbl_out = {sgl_in[31], {3'h0, e} + fplsc_pkg::SGL_TO_DBL_BIAS, fr}; // RQ10
      end
      else if (f == 23'h0)
      begin
         dbl_out = {sgl_in[31], 63'h0};
      end
      else
      begin
         de = fplsc_pkg::SGL_TO_DBL_BIAS; // RQ10
         for (int i = 0; i < 23; i++)
         begin
            if (fr[51] == 1'b0)
            begin
               fr = {fr[50:0], 1'b0};
               de = de - 11'h001;
            end
         end
         fr = {fr[50:0], 1'b0};
         dbl_out = {sgl_in[31], de, fr};
      end
   end
   // ------------------------------------------------------------
   // Narrowing of a double operand
   // ------------------------------------------------------------
   always_comb
   begin
      logic [10:0] de;
      logic [53:0] mant;
      logic [10:0] sh;
      de = dbl_in[62:52];
      mant = {1'b0, 1'b1, dbl_in[51:0]};
      sh = 11'h0;
      if (de > fplsc_pkg::ST_NODENORM_EXP || dbl_in[62:0] == 63'h0)
      begin
         sgl_out = {dbl_in[63:62], dbl_in[58:29]}; // RQ6 RQ7
      end
      else
      begin
         sh = fplsc_pkg::ST_NODENORM_EXP + 11'h001 - de; // RQ10
         mant = (sh > 11'h036) ? 54'h0 : (mant >> sh);
         sgl_out = {dbl_in[63], 8'h00, mant[51:29]}; // RQ9
      end
   end
endmodule // fplsc_convert
`default_nettype wire

/* tb/fplsc_mem_model.sv */
// Memory read side that answers floating-point loads.
// Assumes the address is held while the request is taken.
`timescale 1ns/1ps
`default_nettype none
module fplsc_mem_model
(
   input wire logic [63:0] addr,
   output logic [63:0] rdata
);
   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Low word is the address, high word its inverse
   assign rdata = {~addr[31:0], addr[31:0]};
endmodule // fplsc_mem_model
`default_nettype wire

/* tb/fplsc_checker.sv */
// Assertions on the ports of the conversion datapath.
// Assumes it is bound to fplsc_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fplsc_checker
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire fplsc_pkg::fplsc_op_t op_code,
   input wire logic op_update,
   input wire logic [4:0] base_gpr,
   input wire logic [4:0] fp_target_reg,
   input wire logic [63:0] eff_addr,
   input wire logic [63:0] mem_rdata,
   input wire logic [63:0] fp_source_reg,
   input wire logic fpr_we,
   input wire logic [4:0] fpr_waddr,
   input wire logic [63:0] fpr_wdata,
   input wire logic gpr_we,
   input wire logic [4:0] gpr_waddr,
   input wire logic [63:0] gpr_wdata,
   input wire logic mem_we,
   input wire logic mem_dword,
   input wire logic [63:0] mem_wdata,
   input wire logic invalid_form
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   localparam fplsc_pkg::fplsc_op_t LDS = fplsc_pkg::FPLSC_OP_LD_SINGLE;
   localparam fplsc_pkg::fplsc_op_t LDD = fplsc_pkg::FPLSC_OP_LD_DOUBLE;
   localparam fplsc_pkg::fplsc_op_t STS = fplsc_pkg::FPLSC_OP_ST_SINGLE;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire ld = op_valid && (op_code == LDS || op_code == LDD);
   wire st = op_valid && !(op_code == LDS || op_code == LDD);
   wire ld_ok = ld && !(op_update && base_gpr == 5'h00);
   wire st_plain = fp_source_reg[62:52] > 11'h380 || fp_source_reg[62:0] == 63'h0;
   sequence upd_req;
      ld && op_update && base_gpr != 5'h00;
   endsequence
   a_ld_widen: assert property (ld_ok && op_code == LDS && mem_rdata[30:23] != 8'h00
      && mem_rdata[30:23] != 8'hFF |=> fpr_we && fpr_wdata == {$past(mem_rdata[31:30]),
      {3{!$past(mem_rdata[30])}}, $past(mem_rdata[29:0]), 29'h0}) else $error("widen");
   a_ld_copy: assert property (ld && op_code == LDD && !op_update |=> fpr_we
      && fpr_waddr == $past(fp_target_reg) && fpr_wdata == $past(mem_rdata)) else $error("copy");
   a_ld_no_mem: assert property (ld |=> !mem_we) else $error("load wrote memory");
   a_upd_wb: assert property (upd_req |=> gpr_we && gpr_waddr == $past(base_gpr)
      && gpr_wdata == $past(eff_addr) && fpr_we) else $error("write-back");
   a_upd_zero: assert property (ld && op_update && base_gpr == 5'h00
      |=> invalid_form && !fpr_we && !gpr_we) else $error("invalid form");
   a_st_plain: assert property (op_valid && op_code == STS && st_plain
      |=> mem_we && !mem_dword && mem_wdata == {32'h0,
      $past(fp_source_reg[63:62]), $past(fp_source_reg[58:29])}) else $error("narrow");
   a_st_dbl: assert property (op_valid && op_code == fplsc_pkg::FPLSC_OP_ST_DOUBLE
      |=> mem_we && mem_dword && mem_wdata == $past(fp_source_reg)) else $error("dbl");
   a_st_int: assert property (op_valid && op_code == fplsc_pkg::FPLSC_OP_ST_INTWORD
      |=> mem_we && mem_wdata[31:0] == $past(fp_source_reg[31:0])) else $error("int");
   a_st_no_reg: assert property (st |=> !fpr_we && !gpr_we) else $error("store reg");
endmodule // fplsc_checker
`default_nettype wire

/* tb/fplsc_top_tb.sv */
// Directed bench for the conversion datapath.
// Assumes latency one and the memory model answering from the address.
`timescale 1ns/1ps
`default_nettype none
module fplsc_top_tb;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic op_valid = 1'b0;
   fplsc_pkg::fplsc_op_t op_code = fplsc_pkg::FPLSC_OP_LD_SINGLE;
   logic op_update = 1'b0;
   logic [4:0] base_gpr = 5'h00;
   logic [4:0] fp_target_reg = 5'h00;
   logic [63:0] eff_addr = 64'h0;
   logic [63:0] fp_source_reg = 64'h0;
   logic [63:0] mem_rdata, fpr_wdata, gpr_wdata, mem_wdata;
   logic fpr_we, gpr_we, mem_we, mem_dword, invalid_form;
   logic [4:0] fpr_waddr, gpr_waddr;
   wire [3:0] strb = {fpr_we, gpr_we, mem_we, invalid_form};
   int fail_count = 0;
   int tests_run = 0;
   always #20 core_clk = ~core_clk;
   fplsc_mem_model u_mem (.addr(eff_addr), .rdata(mem_rdata));
   fplsc_top u_dut (.core_clk, .rst_b, .op_valid, .op_code, .op_update, .base_gpr,
      .fp_target_reg, .eff_addr, .mem_rdata, .fp_source_reg, .fpr_we, .fpr_waddr, .fpr_wdata,
      .gpr_we, .gpr_waddr, .gpr_wdata, .mem_we, .mem_dword, .mem_wdata, .invalid_form);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic req(input fplsc_pkg::fplsc_op_t op, input logic u, input logic [4:0] b,
      input logic [63:0] a, input logic [63:0] s);
      op_code = op;
      op_update = u;
      base_gpr = b;
      fp_target_reg = b + 5'h01;
      eff_addr = a;
      fp_source_reg = s;
      op_valid = 1'b1;
      @(posedge core_clk);
      #1;
   endtask
   task automatic t_loads();
      req(fplsc_pkg::FPLSC_OP_LD_SINGLE, 1'b0, 5'h06, 64'h3FC00000, 64'h0);
      chk(fpr_wdata, 64'h3FF8000000000000);
      chk(64'({strb, fpr_waddr}), 64'h107);
      req(fplsc_pkg::FPLSC_OP_LD_SINGLE, 1'b0, 5'h06, 64'h7F800000, 64'h0);
      chk(fpr_wdata, 64'h7FF0000000000000);
      req(fplsc_pkg::FPLSC_OP_LD_SINGLE, 1'b0, 5'h06, 64'h00400000, 64'h0);
      chk(fpr_wdata, 64'h3800000000000000);
      req(fplsc_pkg::FPLSC_OP_LD_SINGLE, 1'b0, 5'h06, 64'h00000001, 64'h0);
      chk(fpr_wdata, 64'h36A0000000000000);
      req(fplsc_pkg::FPLSC_OP_LD_DOUBLE, 1'b0, 5'h06, 64'h01234567, 64'h0);
      chk(fpr_wdata, 64'hFEDCBA9801234567);
   endtask
   task automatic t_update();
      req(fplsc_pkg::FPLSC_OP_LD_DOUBLE, 1'b1, 5'h09, 64'hA5, 64'h0);
      chk(gpr_wdata, 64'hA5);
      chk(64'({strb, gpr_waddr}), 64'h189);
      req(fplsc_pkg::FPLSC_OP_LD_SINGLE, 1'b1, 5'h00, 64'h5A, 64'h0);
      chk(64'(strb), 64'h1);
      req(fplsc_pkg::fplsc_op_t'(3'h5), 1'b0, 5'h02, 64'h0, 64'h0);
      chk(64'(strb), 64'h1);
   endtask
   task automatic t_stores();
      logic [63:0] src [5] = '{64'h3FF8000000000000, 64'h8000000000000000,
         64'h47F0000000000000, 64'h3800000000000000, 64'h36A0000000000000};
      logic [31:0] wrd [5] = '{32'h3FC00000, 32'h80000000, 32'h7F800000, 32'h00400000,
         32'h00000001};
      for (int i = 0; i < 5; i++)
      begin
         req(fplsc_pkg::FPLSC_OP_ST_SINGLE, 1'b0, 5'h00, 64'h0, src[i]);
         chk(mem_wdata, {32'h0, wrd[i]});
         chk(64'({strb, mem_dword}), 64'h4);
      end
      req(fplsc_pkg::FPLSC_OP_ST_DOUBLE, 1'b0, 5'h00, 64'h0, 64'h0123456789ABCDEF);
      chk(mem_wdata, 64'h0123456789ABCDEF);
      req(fplsc_pkg::FPLSC_OP_ST_INTWORD, 1'b0, 5'h00, 64'h0, 64'h0123456789ABCDEF);
      chk(64'(mem_wdata[31:0]), 64'h89ABCDEF);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      t_loads();
      t_update();
      t_stores();
      op_valid = 1'b0;
      @(posedge core_clk);
      #1;
      chk(64'(strb), 64'h0);
      final_report();
   end
endmodule // fplsc_top_tb
bind fplsc_top fplsc_checker u_chk (.core_clk, .rst_b, .op_valid, .op_code, .op_update,
   .base_gpr, .fp_target_reg, .eff_addr, .mem_rdata, .fp_source_reg, .fpr_we, .fpr_waddr,
   .fpr_wdata, .gpr_we, .gpr_waddr, .gpr_wdata, .mem_we, .mem_dword, .mem_wdata, .invalid_form);
`default_nettype wire
